// ==== logic/sac_ctrl.sv ====
// Conversion and read control of a 16-bit successive-approximation converter.
// Assumes host strobes are synchronous to clk_i; the comparator decision
// arrives on cmp_i, and the pad ring resolves three-state data from enables.
`timescale 1ns/1ps
module sac_ctrl #(
  parameter int STEP_DIV = sac_pkg::STEP_DIV,
  parameter int FIFO_DEPTH = sac_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_conv_i,
  input wire logic byte_sel_i,
  input wire logic cmp_i,
  output logic busy_n_o,
  output logic hold_o,
  output logic [15:0] dac_code_o,
  output logic [7:0] upper_data_lines_o,
  output logic [7:0] lower_data_lines_o,
  output logic data_oe_o,
  output logic overrun_o
);
  // The DAC code is registered, so the comparator needs one settling cycle before each step.
  initial begin
    if (STEP_DIV < 2) $error("STEP_DIV must be at least 2");
  end
  localparam int MC = sac_pkg::MIN_START_CYC;
  localparam int SW = $clog2(STEP_DIV + 1);

  sac_pkg::sac_state_e state_q;
  logic [15:0] approx_result_register_q;
  logic [15:0] trial_q;
  logic [SW-1:0] div_q;
  logic [1:0] low_q;
  logic start_req;
  logic step;
  logic res_push;
  logic res_ready;
  logic [15:0] res_data;
  logic res_valid;
  logic res_pop;
  logic [15:0] latch_q;
  logic cs_q;
  logic rc_q;
  sac_pkg::sac_bus_s bus_d;

  // Both strobes low together; qualified by a minimum-width counter so a glitch is no start.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_q <= 2'h0;
    end else if (!cs_n_i && !rd_conv_i) begin
      if (low_q != 2'(MC)) low_q <= low_q + 2'h1;
    end else begin
      low_q <= 2'h0;
    end
  end
  // Start fires once per combined-low interval, on the first qualifying cycle.
  assign start_req = (low_q == 2'(MC - 1)) && !cs_n_i && !rd_conv_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
    end else if (state_q != sac_pkg::SAC_CONV || div_q == SW'(STEP_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign step = (state_q == sac_pkg::SAC_CONV) && (div_q == SW'(STEP_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (start_req) state_q <= sac_pkg::SAC_CONV;
        end
        sac_pkg::SAC_CONV: begin
          // Starts arriving here are ignored.
          if (step && trial_q[0]) state_q <= sac_pkg::SAC_LOAD;
        end
        sac_pkg::SAC_LOAD: begin
          state_q <= sac_pkg::SAC_IDLE;
        end
        default: state_q <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      approx_result_register_q <= sac_pkg::RESULT_RST;
      trial_q <= 16'h0000;
    end else if (state_q == sac_pkg::SAC_IDLE && start_req) begin
      approx_result_register_q <= 16'h0000;
      trial_q <= 16'h8000;
    end else if (step) begin
      // Keep the trial bit if the comparator says the input is at or above the DAC level.
      if (cmp_i) approx_result_register_q <= approx_result_register_q | trial_q;
      trial_q <= trial_q >> 1;
    end
  end

  // The DAC sees the offset-binary trial code; flipping the MSB gives two's complement.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dac_code_o <= 16'h0000;
    end else begin
      dac_code_o <= approx_result_register_q | trial_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_n_o <= 1'b1;
      hold_o <= 1'b0;
    end else if (state_q == sac_pkg::SAC_IDLE && start_req) begin
      busy_n_o <= 1'b0;
      hold_o <= 1'b1;
    end else if (state_q == sac_pkg::SAC_LOAD) begin
      busy_n_o <= 1'b1;
      hold_o <= 1'b0;
    end
  end

  assign res_push = (state_q == sac_pkg::SAC_LOAD);
  // A read window opens when select low with the strobe high follows any other input pair.
  assign res_pop = res_valid && !(!cs_q && rc_q) && !cs_n_i && rd_conv_i;

  // Results queue here so a slow reader never loses a conversion unless the queue is full.
  sac_fifo #(
    .WIDTH(sac_pkg::RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i({~approx_result_register_q[15], approx_result_register_q[14:0]}),
    .in_valid_i(res_push),
    .in_ready_o(res_ready),
    .out_data_o(res_data),
    .out_valid_o(res_valid),
    .out_ready_i(res_pop)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      overrun_o <= 1'b0;
    end else if (res_push && !res_ready) begin
      overrun_o <= 1'b1;
    end
  end

  // Output latch takes the oldest queued result when a read window opens.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cs_q <= 1'b1;
      rc_q <= 1'b0;
      latch_q <= sac_pkg::RESULT_RST;
    end else begin
      cs_q <= cs_n_i;
      rc_q <= rd_conv_i;
      if (res_pop) latch_q <= res_data;
    end
  end

  always_comb begin
    if (byte_sel_i) begin
      bus_d.upper = latch_q[7:0];
      bus_d.lower = latch_q[15:8];
    end else begin
      bus_d.upper = latch_q[15:8];
      bus_d.lower = latch_q[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_oe_o <= 1'b0;
      upper_data_lines_o <= 8'h00;
      lower_data_lines_o <= 8'h00;
    end else begin
      data_oe_o <= !cs_n_i && rd_conv_i;
      upper_data_lines_o <= bus_d.upper;
      lower_data_lines_o <= bus_d.lower;
    end
  end

  // Checking aids below are read only by assertions.
  // A repetition over the whole conversion would unroll badly, so its length is counted.
  localparam int CONV_CYC = sac_pkg::RES_BITS * STEP_DIV + 1;
  localparam int CW = $clog2(CONV_CYC + 2);
  logic [CW-1:0] busy_cnt_q;
  logic [4:0] bit_cnt_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= '0;
    end else if (busy_n_o) begin
      busy_cnt_q <= '0;
    end else if (busy_cnt_q != CW'(CONV_CYC + 1)) begin
      busy_cnt_q <= busy_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_q <= 5'h00;
    end else if (state_q == sac_pkg::SAC_IDLE && start_req) begin
      bit_cnt_q <= 5'h00;
    end else if (step && bit_cnt_q != 5'h1F) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Steps of one conversion, used to build the properties below.
  sequence s_start;
    state_q == sac_pkg::SAC_IDLE && start_req;
  endsequence
  sequence s_conv_entry;
    state_q == sac_pkg::SAC_CONV && trial_q == 16'h8000 && !busy_n_o && hold_o;
  endsequence
  sequence s_load;
    state_q == sac_pkg::SAC_LOAD;
  endsequence
  sequence s_result_out;
    busy_n_o && !hold_o && state_q == sac_pkg::SAC_IDLE;
  endsequence

  a_busy_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_IDLE && start_req) |=> !busy_n_o)
    else $error("busy did not fall on start");
  a_no_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_CONV) |=> state_q != sac_pkg::SAC_IDLE)
    else $error("conversion restarted early");
  a_busy_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(busy_n_o) |-> $past(state_q) == sac_pkg::SAC_IDLE && $past(start_req))
    else $error("busy fell without an accepted start");
  a_busy_conv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_CONV) |-> !busy_n_o)
    else $error("busy high during conversion");
  a_idle_busy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_IDLE && !start_req) |=> busy_n_o)
    else $error("busy low while idle");
  a_conv_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(busy_n_o) |-> busy_cnt_q == CW'(CONV_CYC))
    else $error("conversion length wrong");
  a_busy_rise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(busy_n_o) |-> $past(state_q) == sac_pkg::SAC_LOAD)
    else $error("busy rose without load");

  a_start_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_start |=> s_conv_entry)
    else $error("conversion did not begin on start");
  a_hold_conv: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_CONV) |-> hold_o)
    else $error("sample not held during conversion");
  a_load_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load |=> s_result_out)
    else $error("busy or hold not released after load");

  a_clear_sar: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_IDLE && start_req) |=> approx_result_register_q == 16'h0000)
    else $error("register not cleared at start");
  a_msb_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_IDLE && start_req) |=> trial_q == 16'h8000)
    else $error("first trial not MSB");
  a_trial_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_CONV) |-> $onehot(trial_q))
    else $error("trial code not a single bit");
  a_trial_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (step && !trial_q[0]) |=> trial_q == ($past(trial_q) >> 1))
    else $error("trial bit did not move down one place");
  a_bits_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load |-> bit_cnt_q == 5'h10)
    else $error("wrong number of bit decisions");
  a_load_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_load |-> $past(step))
    else $error("load without a final step");
  a_div_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    div_q < SW'(STEP_DIV))
    else $error("step divider out of range");
  a_dac_trial: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_q == sac_pkg::SAC_CONV) |=> dac_code_o == ($past(approx_result_register_q) | $past(trial_q)))
    else $error("trial code not presented");

  // Output checks: enables and byte steering on the pins, and the read latch behind them.
  a_float_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_conv_i |=> !data_oe_o)
    else $error("outputs driven while strobe low");
  a_cs_float: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cs_n_i |=> !data_oe_o)
    else $error("outputs driven while deselected");
  a_read_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!cs_n_i && rd_conv_i) |=> data_oe_o)
    else $error("outputs not driven in read window");
  a_read_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    res_pop |=> latch_q == $past(res_data))
    else $error("read did not take the oldest result");
  a_latch_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !res_pop |=> $stable(latch_q))
    else $error("latch changed without a read");
  a_byte_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    byte_sel_i |=> upper_data_lines_o == $past(latch_q[7:0]))
    else $error("byte swap wrong");
  a_low_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    byte_sel_i |=> lower_data_lines_o == $past(latch_q[15:8]))
    else $error("swapped lower byte wrong");
  a_byte_norm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !byte_sel_i |=> upper_data_lines_o == $past(latch_q[15:8]))
    else $error("upper byte wrong");
  a_low_norm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !byte_sel_i |=> lower_data_lines_o == $past(latch_q[7:0]))
    else $error("lower byte wrong");
endmodule

// ==== logic/sac_pkg.sv ====
// Shared constants and carriers for the converter control block.
// Assumes a single 20 MHz clock shared by every design file.
package sac_pkg;
  localparam int CLK_MHZ = 20;
  localparam int RES_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int MIN_START_NS = 40;
  localparam int MIN_START_CYC = (MIN_START_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_DIV = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_LOAD = 2'b11
  } sac_state_e;

  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
  } sac_bus_s;
endpackage

// ==== logic/sac_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
// Assumes the single block clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;
  assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// ==== tb/sac_cmp_model.sv ====
// Comparator stand-in that answers each trial code against a held target.
// Assumes the trial code is offset binary and settles within one cycle.
`timescale 1ns/1ps
module sac_cmp_model (
  input wire logic [15:0] dac_code_i,
  input wire logic [15:0] target_i,
  output logic cmp_o
);
  // Keeping a bit while the trial stays at or below the target walks to it.
  assign cmp_o = (dac_code_i <= target_i);
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the converter control block.
// Assumes the comparator stand-in and a short step divider.
`timescale 1ns/1ps
module testbench;
  localparam int SD = 2;
  localparam logic [15:0] CRN [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n = 1'b1;
  logic rc = 1'b0;
  logic bs = 1'b0;
  logic [15:0] tgt = 16'h0000;
  logic cmp, busy_n, hold, oe, ovr;
  logic [15:0] dac;
  logic [7:0] up, lo;
  int failures = 0;
  int check_count = 0;
  logic [15:0] q[$];
  initial forever #25 clk_i = ~clk_i;
  sac_ctrl #(.STEP_DIV(SD), .FIFO_DEPTH(32)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n), .rd_conv_i(rc), .byte_sel_i(bs), .cmp_i(cmp), .busy_n_o(busy_n),
    .hold_o(hold), .dac_code_o(dac), .upper_data_lines_o(up), .lower_data_lines_o(lo),
    .data_oe_o(oe), .overrun_o(ovr));
  sac_cmp_model cmp_u (.dac_code_i(dac), .target_i(tgt), .cmp_o(cmp));
  function automatic logic [15:0] twos(input logic [15:0] t);
    return {~t[15], t[14:0]};
  endfunction
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 200) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // Idle is select high with the strobe low, so no read window opens between runs.
  task automatic convert(input logic [15:0] t, input bit m1, input bit retry);
    int n;
    @(posedge clk_i);
    tgt <= t;
    cs_n <= !m1;
    rc <= m1;
    @(posedge clk_i);
    cs_n <= 1'b0;
    rc <= 1'b0;
    @(posedge clk_i);
    cs_n <= !m1;
    rc <= m1;
    @(negedge clk_i);
    check("oe_low", oe, 16'h0000);
    n = 0;
    while (busy_n !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    bound(n);
    check("hold", hold, 16'h0001);
    n = 0;
    while (busy_n === 1'b0 && n < 200) begin
      @(posedge clk_i);
      if (retry && n == 3) cs_n <= 1'b0;
      if (retry && n == 5) cs_n <= 1'b1;
      @(negedge clk_i);
      n++;
    end
    bound(n);
    check("busy_len", 16'(n), 16'(16 * SD + 1));
    check("hold_end", hold, 16'h0000);
    check("dac_final", dac, t);
    @(posedge clk_i);
    cs_n <= 1'b1;
    rc <= 1'b0;
  endtask
  task automatic read_word(input logic [15:0] e);
    int n;
    @(posedge clk_i);
    rc <= 1'b1;
    bs <= 1'b0;
    @(posedge clk_i);
    cs_n <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (oe !== 1'b1 && n < 200);
    bound(n);
    @(negedge clk_i);
    check("word", {up, lo}, e);
    @(posedge clk_i);
    bs <= 1'b1;
    repeat (2) @(negedge clk_i);
    check("swap", {up, lo}, {e[7:0], e[15:8]});
    @(posedge clk_i);
    cs_n <= 1'b1;
    rc <= 1'b0;
  endtask
  initial begin
    logic [15:0] t;
    void'($urandom(96317));
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      t = (i < 4) ? CRN[i] : 16'($urandom());
      convert(t, i[0], i == 2);
      read_word(twos(t));
      $display("test single %0d done", i);
    end
    // Fill past depth with no reads, then drain and confirm order.
    for (int i = 0; i < 33; i++) begin
      t = 16'($urandom());
      if (i < 32) q.push_back(t);
      convert(t, 1'b0, 1'b0);
      if (i >= 31) check("overrun", ovr, (i == 32) ? 16'h0001 : 16'h0000);
    end
    while (q.size() > 0) read_word(twos(q.pop_front()));
    $display("test fifo done");
    tally_and_finish();
  end
endmodule
